//--- hdl/dtc_timer.sv
// dual timer/counter with four modes behind an AHB-Lite register slave
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.svh"
// Notes on behaviour
// - timer function counts once per machine cycle, every two clocks
// - counter function counts each falling edge on the count pin
// - low and high count bytes are 8 bits, cleared by reset
// - run bit changes never alter the count bytes
// - overflow sets the flag; interrupt request when its enable is set
// - flag clears automatically on entry to its service routine
// - count only when run set and gate select clear or gate input high
// - external gate does not act on timer one in split mode
// - two-bit mode field picks one of four modes; 0..2 independent
// - mode 00 13-bit, 01 16-bit, 10 reload, 11 split; bits 1:0, 5:4
// - mode 0 counts high byte above low five bits of low byte
// - mode 0 rollover from all ones sets the overflow flag
// - mode 1 counts all sixteen bits and overflows to zero
// - mode 2 low byte overflow sets flag, reloads low from high
// - split mode: timer zero high byte counts cycles with timer one controls
// - timer one in split mode holds its count as if stopped
// - timer one resumes when moved out of split mode, stops back in it
// - input selector picks machine cycle tick or external count pin
// - selector 0 is machine cycle tick, 1 is the count pin
// - each count pin comes from one of two sources
// - source bit 0 for timer zero, bit 1 for timer one; 1 picks alternate
module dtc_timer
   import dtc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire dtc_pkg::dtc_pins_t timer_zero_pins,
   input wire dtc_pkg::dtc_pins_t timer_one_pins,
   input wire logic [1:0] isr_enter,
   output logic [1:0] irq_req
);
   import dtc_pkg::*;
   // the highest word index needs ten byte-address bits
   if (ADDR_W < 10 || ADDR_W > 12)
   begin : g_bad_addr_w
      $error("dtc_timer: ADDR_W must be 10 to 12");
   end

   // the map holds word indices; the two byte-lane bits of the address are dropped
   function automatic logic [11:0] word_addr(input logic [ADDR_W-1:0] a);
      logic [11:0] w;
      w = 12'h000;
      w[ADDR_W-1-`DTC_IDX_LSB:0] = a[ADDR_W-1:`DTC_IDX_LSB];
      return w;
   endfunction

   // ==========================================================
   // pin conditioning
   logic [1:0] gate_level;
   logic [1:0] count_fall;
   logic [7:0] input_source_select_reg;
   dtc_pin_sync u_sync0 (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .pins(timer_zero_pins),
      .source_sel(input_source_select_reg[0]),
      .gate_level(gate_level[0]),
      .count_fall(count_fall[0])
   );
   dtc_pin_sync u_sync1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .pins(timer_one_pins),
      .source_sel(input_source_select_reg[1]),
      .gate_level(gate_level[1]),
      .count_fall(count_fall[1])
   );

   // ==========================================================
   // registers
   logic [7:0] timer_control_reg, next_control;
   logic [7:0] timer_mode_reg, next_mode;
   logic [7:0] irq_enable_reg, next_irq_en;
   logic [7:0] next_psel;
   logic [7:0] count_low_byte [2], next_low [2];
   logic [7:0] count_high_byte [2], next_high [2];
   logic mc_phase, next_mc_phase;
   dtc_bus_state_t bus_state, next_bus_state;
   logic [11:0] bus_addr, next_bus_addr;
   logic [31:0] next_hrdata;
   logic [1:0] next_irq_req;

   dtc_mode_t mode [2];
   assign mode[0] = dtc_mode_t'(timer_mode_reg[`DTC_MOD_T0_MODE]);
   assign mode[1] = dtc_mode_t'(timer_mode_reg[`DTC_MOD_T1_MODE]);

   // machine cycle tick: every second enabled clock
   logic mc_tick;
   assign mc_tick = clk_en & mc_phase;

   // ==========================================================
   // count enables
   logic [1:0] run, gate_sel, insel, tick, low_en;
   logic high0_split_en;
   assign run = {timer_control_reg[`DTC_CTL_T1_RUN], timer_control_reg[`DTC_CTL_T0_RUN]};
   assign gate_sel = {timer_mode_reg[`DTC_MOD_T1_GATE], timer_mode_reg[`DTC_MOD_T0_GATE]};
   assign insel = {timer_mode_reg[`DTC_MOD_T1_INSEL], timer_mode_reg[`DTC_MOD_T0_INSEL]};
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_en
         assign tick[g] = insel[g] ? count_fall[g] : mc_tick;
         assign low_en[g] = tick[g] & run[g] & (~gate_sel[g] | gate_level[g]);
      end
   endgenerate
   // timer one frozen in split mode regardless of its run bit; no gate applies then
   logic t1_en;
   assign t1_en = (mode[1] != DTC_MODE_SPLIT) & low_en[1];
   assign high0_split_en = mc_tick & run[1];

   // one timer's next count from the current bytes, its mode and an enable
   function automatic dtc_count_t step(input logic [7:0] lo, input logic [7:0] hi,
                                       input dtc_mode_t m, input logic en);
      dtc_count_t r;
      r.low = lo;
      r.high = hi;
      r.carry_low = 1'b0;
      r.carry_high = 1'b0;
      if (en)
      begin
         case (m)
            DTC_MODE_13BIT:
            begin
               r.low = {lo[7:5], lo[4:0] + 5'h01};
               if (lo[4:0] == `DTC_PRE_TOP)
               begin
                  r.high = hi + 8'h01;
                  r.carry_low = (hi == 8'hFF);
               end
            end
            DTC_MODE_16BIT:
            begin
               r.low = lo + 8'h01;
               if (lo == 8'hFF)
               begin
                  r.high = hi + 8'h01;
                  r.carry_low = (hi == 8'hFF);
               end
            end
            DTC_MODE_RELOAD:
            begin
               r.low = (lo == 8'hFF) ? hi : lo + 8'h01;
               r.carry_low = (lo == 8'hFF);
            end
            DTC_MODE_SPLIT:
            begin
               r.low = lo + 8'h01;
               r.carry_low = (lo == 8'hFF);
            end
            default:
            begin
               r.low = lo;
            end
         endcase
      end
      return r;
   endfunction

   dtc_count_t c0, c1;
   logic h0_carry;
   logic [7:0] h0_split;
   always_comb
   begin
      c0 = step(count_low_byte[0], count_high_byte[0], mode[0], low_en[0]);
      c1 = step(count_low_byte[1], count_high_byte[1], mode[1], t1_en);
      h0_split = count_high_byte[0];
      h0_carry = 1'b0;
      if (mode[0] == DTC_MODE_SPLIT && high0_split_en)
      begin
         h0_split = count_high_byte[0] + 8'h01;
         h0_carry = (count_high_byte[0] == 8'hFF);
      end
   end

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   logic take;
   assign take = hsel & hready & htrans[1];

   function automatic logic [7:0] read_byte(input logic [11:0] a, input logic [7:0] ctl,
                                            input logic [7:0] md, input logic [7:0] ien,
                                            input logic [7:0] ps, input logic [7:0] l0,
                                            input logic [7:0] l1, input logic [7:0] h0,
                                            input logic [7:0] h1, input logic [1:0] irq);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         `DTC_OFS_CONTROL: d = ctl;
         `DTC_OFS_MODE: d = md;
         `DTC_OFS_T0_LOW: d = l0;
         `DTC_OFS_T1_LOW: d = l1;
         `DTC_OFS_T0_HIGH: d = h0;
         `DTC_OFS_T1_HIGH: d = h1;
         `DTC_OFS_IRQ_EN: d = ien;
         `DTC_OFS_PIN_SEL: d = ps;
         `DTC_OFS_STATUS: d = {6'h00, irq};
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   logic wr;
   logic [7:0] wd;
   assign wr = clk_en & (bus_state == DTC_BUS_WRITE);
   assign wd = hwdata[7:0];

   always_comb
   begin
      next_bus_state = bus_state;
      next_bus_addr = bus_addr;
      next_hrdata = hrdata;
      if (clk_en)
      begin
         next_bus_state = DTC_BUS_IDLE;
         if (take)
         begin
            next_bus_state = hwrite ? DTC_BUS_WRITE : DTC_BUS_READ;
            next_bus_addr = word_addr(haddr);
            if (!hwrite)
               next_hrdata = {24'h000000, read_byte(word_addr(haddr), timer_control_reg,
                  timer_mode_reg, irq_enable_reg, input_source_select_reg,
                  count_low_byte[0], count_low_byte[1], count_high_byte[0],
                  count_high_byte[1], irq_req)};
         end
      end
   end

   // ==========================================================
   // register and count updates; hardware set beats software clear
   logic [1:0] ovf_set;
   logic [1:0] ack;
   always_comb
   begin
      ovf_set[0] = c0.carry_low;
      ovf_set[1] = (mode[0] == DTC_MODE_SPLIT) ? h0_carry : c1.carry_low;
      ack = clk_en ? isr_enter : 2'b00;
      if (wr && bus_addr == `DTC_OFS_IRQ_ACK)
         ack = ack | wd[1:0];
      next_control = timer_control_reg;
      next_mode = timer_mode_reg;
      next_irq_en = irq_enable_reg;
      next_psel = input_source_select_reg;
      next_low = count_low_byte;
      next_high = count_high_byte;
      next_mc_phase = mc_phase;
      if (clk_en)
      begin
         next_mc_phase = ~mc_phase;
         // run bit writes touch only the control byte, never the counts
         if (wr && bus_addr == `DTC_OFS_CONTROL)
            next_control = wd & `DTC_CTL_MASK;
         if (wr && bus_addr == `DTC_OFS_MODE)
            next_mode = wd;
         if (wr && bus_addr == `DTC_OFS_IRQ_EN)
            next_irq_en = wd & `DTC_IEN_MASK;
         if (wr && bus_addr == `DTC_OFS_PIN_SEL)
            next_psel = wd & `DTC_PSEL_MASK;
         next_low[0] = c0.low;
         next_high[0] = (mode[0] == DTC_MODE_SPLIT) ? h0_split : c0.high;
         next_low[1] = c1.low;
         next_high[1] = c1.high;
         if (wr && bus_addr == `DTC_OFS_T0_LOW)
            next_low[0] = wd;
         if (wr && bus_addr == `DTC_OFS_T1_LOW)
            next_low[1] = wd;
         if (wr && bus_addr == `DTC_OFS_T0_HIGH)
            next_high[0] = wd;
         if (wr && bus_addr == `DTC_OFS_T1_HIGH)
            next_high[1] = wd;
         if (ack[0])
            next_control[`DTC_CTL_T0_OVF] = 1'b0;
         if (ack[1])
            next_control[`DTC_CTL_T1_OVF] = 1'b0;
         if (ovf_set[0])
            next_control[`DTC_CTL_T0_OVF] = 1'b1;
         if (ovf_set[1])
            next_control[`DTC_CTL_T1_OVF] = 1'b1;
      end
      next_irq_req[0] = next_control[`DTC_CTL_T0_OVF] & next_irq_en[`DTC_IEN_T0];
      next_irq_req[1] = next_control[`DTC_CTL_T1_OVF] & next_irq_en[`DTC_IEN_T1];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         timer_control_reg <= `DTC_RST_BYTE;
         timer_mode_reg <= `DTC_RST_BYTE;
         irq_enable_reg <= `DTC_RST_BYTE;
         input_source_select_reg <= `DTC_RST_BYTE;
         count_low_byte[0] <= `DTC_RST_BYTE;
         count_low_byte[1] <= `DTC_RST_BYTE;
         count_high_byte[0] <= `DTC_RST_BYTE;
         count_high_byte[1] <= `DTC_RST_BYTE;
         mc_phase <= 1'b0;
         bus_state <= DTC_BUS_IDLE;
         bus_addr <= 12'h000;
         hrdata <= 32'h00000000;
         irq_req <= 2'b00;
      end
      else
      begin
         timer_control_reg <= next_control;
         timer_mode_reg <= next_mode;
         irq_enable_reg <= next_irq_en;
         input_source_select_reg <= next_psel;
         count_low_byte <= next_low;
         count_high_byte <= next_high;
         mc_phase <= next_mc_phase;
         bus_state <= next_bus_state;
         bus_addr <= next_bus_addr;
         hrdata <= next_hrdata;
         irq_req <= next_irq_req;
      end
   end

   // no wait states and no error answer; both held as flops for constant outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule // dtc_timer
`default_nettype wire

//--- hdl/dtc_map.svh
// register word indices, field positions, reset values and timing counts of the dual timer
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
// each register owns one aligned word: byte address is the index shifted up by this many bits
`define DTC_IDX_LSB 2
`define DTC_OFS_CONTROL 12'h088
`define DTC_OFS_MODE 12'h089
`define DTC_OFS_T0_LOW 12'h08A
`define DTC_OFS_T1_LOW 12'h08B
`define DTC_OFS_T0_HIGH 12'h08C
`define DTC_OFS_T1_HIGH 12'h08D
`define DTC_OFS_IRQ_EN 12'h0A8
`define DTC_OFS_PIN_SEL 12'h0B0
`define DTC_OFS_IRQ_ACK 12'h0B4
`define DTC_OFS_STATUS 12'h0B8
`define DTC_CTL_T0_RUN 4
`define DTC_CTL_T0_OVF 5
`define DTC_CTL_T1_RUN 6
`define DTC_CTL_T1_OVF 7
`define DTC_MOD_T0_MODE 1:0
`define DTC_MOD_T0_INSEL 2
`define DTC_MOD_T0_GATE 3
`define DTC_MOD_T1_MODE 5:4
`define DTC_MOD_T1_INSEL 6
`define DTC_MOD_T1_GATE 7
`define DTC_IEN_T0 1
`define DTC_IEN_T1 3
`define DTC_IEN_MASK 8'h0A
`define DTC_PSEL_MASK 8'h03
`define DTC_CTL_MASK 8'hF0
`define DTC_RST_BYTE 8'h00
`define DTC_PRE_TOP 5'h1F
`define DTC_MC_DIV 2
`endif

//--- hdl/dtc_pkg.sv
// types shared by the dual timer design
package dtc_pkg;
   typedef enum logic [1:0] {DTC_MODE_13BIT, DTC_MODE_16BIT, DTC_MODE_RELOAD, DTC_MODE_SPLIT}
      dtc_mode_t;
   typedef enum logic [1:0] {DTC_BUS_IDLE, DTC_BUS_WRITE, DTC_BUS_READ} dtc_bus_state_t;
   typedef struct packed {
      logic count_pin_a;
      logic count_pin_b;
      logic gate_in;
   } dtc_pins_t;
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic carry_low;
      logic carry_high;
   } dtc_count_t;
endpackage

//--- hdl/dtc_pin_sync.sv
// synchroniser and falling-edge detector for one timer's external pins
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_sync
   import dtc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire dtc_pkg::dtc_pins_t pins,
   input wire logic source_sel,
   output logic gate_level,
   output logic count_fall
);
   import dtc_pkg::*;
   // ==========================================================
   // two-stage synchronisers
   logic [2:0] meta, next_meta;
   logic [2:0] sync, next_sync;
   logic last_count, next_last_count;
   always_comb
   begin
      next_meta = meta;
      next_sync = sync;
      next_last_count = last_count;
      if (clk_en)
      begin
         next_meta = {pins.count_pin_a, pins.count_pin_b, pins.gate_in};
         next_sync = meta;
         // source chosen after the second stage, so a switch cannot forge an edge from meta
         next_last_count = source_sel ? sync[1] : sync[2];
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta <= 3'h7;
         sync <= 3'h7;
         last_count <= 1'b1;
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         last_count <= next_last_count;
      end
   end
   assign gate_level = sync[0];
   // one-cycle enable on a high-to-low transition
   assign count_fall = clk_en & last_count & ~(source_sel ? sync[1] : sync[2]);
endmodule // dtc_pin_sync
`default_nettype wire

//--- bench/dtc_timer_chk.sv
// port assertions for the dual timer
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_chk
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] isr_enter,
   input wire logic [1:0] irq_req
);
   // ==========
   // bus qualifiers
   logic wr_go;
   logic rd_go;
   assign wr_go = hsel && hready && htrans[1] && hwrite && clk_en;
   assign rd_go = hsel && hready && htrans[1] && !hwrite && clk_en;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ==========
   // properties
   property p_isr_clears0;
      isr_enter[0] && clk_en |=> !irq_req[0];
   endproperty
   a_isr_clears0: assert property (p_isr_clears0)
      else $error("timer zero request survived isr entry");
   property p_isr_clears1;
      isr_enter[1] && clk_en |=> !irq_req[1];
   endproperty
   a_isr_clears1: assert property (p_isr_clears1)
      else $error("timer one request survived isr entry");
   property p_reset_quiet;
      $rose(hresetn) |-> irq_req == 2'b00 && hrdata == 32'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not cleared by reset");
   property p_freeze;
      !clk_en |=> $stable(irq_req) && $stable(hrdata);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");
   property p_hi_zero;
      hrdata[31:8] == 24'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("read data above byte lane not zero");
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay)
      else $error("slave not ready or not okay");
   property p_rd_hold;
      !rd_go |=> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");
   // timer zero's request may only drop after isr entry or a register write
   property p_fall_cause0;
      $fell(irq_req[0]) |-> $past(isr_enter[0]) || $past(wr_go, 2);
   endproperty
   a_fall_cause0: assert property (p_fall_cause0)
      else $error("timer zero request dropped without cause");
endmodule // dtc_timer_chk
`default_nettype wire

//--- bench/dtc_pin_model.sv
// model of the external count and gate pins of both timers
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model
   import dtc_pkg::*;
(
   input wire logic hclk,
   output var dtc_pkg::dtc_pins_t timer_zero_pins,
   output var dtc_pkg::dtc_pins_t timer_one_pins
);
   // ==========
   // pin drive
   // count pins rest high, as with a pull-up, so only a real pulse is a fall
   initial
   begin
      timer_zero_pins = 3'b110;
      timer_one_pins = 3'b110;
   end
   // gate is a plain level, edge detection bypassed
   task automatic set_gate(input int t, input logic v);
      if (t == 0)
         timer_zero_pins.gate_in <= v;
      else
         timer_one_pins.gate_in <= v;
   endtask
   task automatic falls(input int t, input int s, input int n, input int gap);
      dtc_pkg::dtc_pins_t v;
      v = (t == 0) ? timer_zero_pins : timer_one_pins;
      repeat (n)
      begin
         for (int h = 0; h < 2; h++)
         begin
            if (s == 0)
               v.count_pin_a = h[0];
            else
               v.count_pin_b = h[0];
            @(posedge hclk);
            if (t == 0)
               timer_zero_pins <= v;
            else
               timer_one_pins <= v;
            repeat (gap) @(posedge hclk);
         end
      end
   endtask
endmodule // dtc_pin_model
`default_nettype wire

//--- bench/test_dual_timer_counter_four_modes.sv
// self-checking bench for the dual timer
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_counter_four_modes;
   import dtc_pkg::*;
   // ==========
   // signals and instances
   logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0] htrans, isr_enter, irq_req;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   dtc_pins_t p0, p1;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   dtc_timer i_dtc_timer (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timer_zero_pins(p0), .timer_one_pins(p1), .isr_enter(isr_enter), .irq_req(irq_req));
   dtc_pin_model i_dtc_pin_model (.hclk(hclk), .timer_zero_pins(p0), .timer_one_pins(p1));
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_fail++;
         stop_test();
      end
   end
   // ==========
   // shared tasks
   // registers sit on aligned words: the byte address is four times the index
   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] lo, input logic [7:0] hi,
      input logic [7:0] got);
      compares++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         n_fail++;
         $display("unexpected %s: expected %0h..%0h seen %0h", what, lo, hi, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      q = hrdata[7:0];
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] lo,
      input logic [7:0] hi);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check(what, lo, hi, q);
   endtask
   task automatic isr(input logic [1:0] b);
      check("flag set", {6'h0, b}, {6'h0, b}, {6'h0, irq_req & b});
      @(posedge hclk);
      isr_enter <= b;
      @(posedge hclk);
      isr_enter <= 2'b00;
      @(negedge hclk);
      check("flag cleared", 8'h00, 8'h00, {6'h0, irq_req & b});
   endtask
   // request sampled half a cycle after the edge, away from the update
   task automatic wait_irq(input int b, input logic [7:0] lo, input logic [7:0] hi);
      int n;
      n = 0;
      do
      begin
         @(negedge hclk);
         n++;
      end
      while (irq_req[b] !== 1'b1 && n < 60);
      check("cycles to overflow", lo, hi, n[7:0]);
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      logic [7:0] a[8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA8, 8'hB0};
      foreach (a[i])
         rd_chk("reset value", ba(a[i]), 8'h00, 8'h00);
      wr(ba(8'h04), 8'h5A);
      rd_chk("unmapped", ba(8'h04), 8'h00, 8'h00);
      wr(ba(8'hA8), 8'hFF);
      rd_chk("irq enable", ba(8'hA8), 8'h0A, 8'h0A);
      wr(ba(8'hB0), 8'hFF);
      rd_chk("pin source", ba(8'hB0), 8'h03, 8'h03);
      $display("test reset done");
   endtask
   task automatic t_overflow();
      logic [7:0] tab[3][5] = '{'{8'h1C, 8'hFF, 8'h00, 8'h03, 8'h00},
         '{8'hFC, 8'hFF, 8'h00, 8'h03, 8'h00}, '{8'hFC, 8'h80, 8'h80, 8'h83, 8'h80}};
      for (int m = 0; m < 3; m++)
      begin
         wr(ba(8'h89), m[7:0]);
         wr(ba(8'h8A), tab[m][0]);
         wr(ba(8'h8C), tab[m][1]);
         wr(ba(8'h88), 8'h10);
         wait_irq(0, 8'h06, 8'h09);
         // stop but write the flag back as set, so the service entry has one to clear
         wr(ba(8'h88), 8'h20);
         rd_chk("low after wrap", ba(8'h8A), tab[m][2], tab[m][3]);
         rd_chk("high after wrap", ba(8'h8C), tab[m][4], tab[m][4]);
         isr(2'b01);
      end
      $display("test overflow done");
   endtask
   task automatic t_counter();
      for (int t = 0; t < 2; t++)
      begin
         wr(ba(8'h89), t ? 8'h50 : 8'h05);
         wr(ba(8'h8A + t[7:0]), 8'h00);
         wr(ba(8'h88), t ? 8'h40 : 8'h10);
         i_dtc_pin_model.falls(t, 0, 3, 2);
         i_dtc_pin_model.falls(t, 1, 2, 2);
         i_dtc_pin_model.falls(t, 1, 3, 6);
         repeat (6) @(posedge hclk);
         wr(ba(8'h88), 8'h00);
         rd_chk("pin falls", ba(8'h8A + t[7:0]), 8'h05, 8'h05);
      end
      $display("test counter done");
   endtask
   task automatic t_gate();
      logic [7:0] q;
      wr(ba(8'h89), 8'h09);
      wr(ba(8'h8A), 8'h00);
      wr(ba(8'h88), 8'h10);
      rd_chk("gated low", ba(8'h8A), 8'h00, 8'h00);
      i_dtc_pin_model.set_gate(0, 1'b1);
      repeat (10) @(posedge hclk);
      clk_en <= 1'b0;
      repeat (20) @(posedge hclk);
      clk_en <= 1'b1;
      wr(ba(8'h88), 8'h00);
      bus(1'b0, ba(8'h8A), 8'h00, q);
      check("gate open", 8'h03, 8'h0A, q);
      repeat (10) @(posedge hclk);
      rd_chk("held on stop", ba(8'h8A), q, q);
      $display("test gate done");
   endtask
   task automatic t_split();
      wr(ba(8'h89), 8'h33);
      wr(ba(8'h8B), 8'h40);
      wr(ba(8'h8C), 8'hF8);
      wr(ba(8'h88), 8'h40);
      wait_irq(1, 8'h0E, 8'h12);
      rd_chk("timer one held", ba(8'h8B), 8'h40, 8'h40);
      wr(ba(8'h89), 8'h13);
      repeat (10) @(posedge hclk);
      wr(ba(8'h89), 8'h33);
      rd_chk("timer one resumed", ba(8'h8B), 8'h42, 8'h48);
      wr(ba(8'h88), 8'h80);
      rd_chk("status", ba(8'hB8), 8'h02, 8'h02);
      isr(2'b10);
      $display("test split done");
   endtask
   // ==========
   // main sequence
   initial
   begin
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      isr_enter = 2'b00;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_overflow();
      t_counter();
      t_gate();
      t_split();
      stop_test();
   end
endmodule // test_dual_timer_counter_four_modes
bind dtc_timer dtc_timer_chk i_dtc_timer_chk (.hclk(hclk), .hresetn(hresetn),
   .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .isr_enter(isr_enter),
   .irq_req(irq_req));
`default_nettype wire
